// ---- core/wutc_pkg.sv ----
// constants shared by the wake-up timer core and its bench
// assumes a 250 MHz core clock and a one-second time base derived from it
//
// Functional notes
// - count from zero after reset pin rises
// - raise interrupt when count equals wake value
// - counter holds while interrupt is high
// - reset pin low clears the counter
// - reset pin low drops interrupt, release resumes counting
// - wake value write clears and restarts counter
// - no interrupt without a written wake value
// - unarmed counter saturates at all ones
// - live count readable at any time
// - counter is 24-bit binary up counter
// - counter advances once per second
// - wake value is 3-byte readable register
// - live count is read-only
package wutc_pkg;

   localparam int CNT_W = 24;
   localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
   localparam logic [CNT_W-1:0] CNT_RESET = 24'h000000;
   localparam int CORE_CLK_HZ = 250000000;
   localparam int TICK_PERIOD_S = 1;
   localparam int TICK_CYCLES = TICK_PERIOD_S * CORE_CLK_HZ;
   localparam int SEC_W = 28;

   typedef enum logic [3:0] {
      ST_HELD = 4'h1,
      ST_COUNT = 4'h2,
      ST_MATCH = 4'h4,
      ST_SAT = 4'h8
   } wutc_state_t;

endpackage : wutc_pkg

// ---- core/wutc_core.sv ----
// wake-up timer core: one-second counter, wake compare, write and read link
// assumes the reset pin is asynchronous and the link clock is unrelated to core_clk_i
`timescale 1ns/10ps

module wutc_core #(
   parameter int TICK_CYCLES = wutc_pkg::TICK_CYCLES
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic timer_rst_n_i,
   output logic int_o,
   input wire logic link_clk_i,
   input wire logic wake_wr_i,
   input wire logic [wutc_pkg::CNT_W-1:0] wake_data_i,
   output logic wake_busy_o,
   output logic [wutc_pkg::CNT_W-1:0] wake_val_o,
   output logic [wutc_pkg::CNT_W-1:0] time_o
);

   ////////////////////////////////////////////////////////////////////////////
   // core domain state

   wutc_pkg::wutc_state_t state, next_state;
   logic [wutc_pkg::CNT_W-1:0] cnt, next_cnt;
   logic [wutc_pkg::CNT_W-1:0] wake, next_wake;
   logic [wutc_pkg::SEC_W-1:0] sec, next_sec;
   logic irq, next_irq;
   logic armed, next_armed;
   logic pin_sync;
   logic req_sync, req_seen;
   logic snap_tgl, next_snap_tgl;
   logic [wutc_pkg::CNT_W-1:0] snap_hold, next_snap_hold;
   logic sack_sync;
   logic wr_evt;
   logic sec_end;

   // link domain state
   logic [wutc_pkg::CNT_W-1:0] wake_hold, next_wake_hold;
   logic req_tgl, next_req_tgl;
   logic ack_sync;
   logic busy, next_busy;
   logic snap_sync, snap_seen, next_snap_seen;
   logic [wutc_pkg::CNT_W-1:0] time_rd, next_time_rd;
   logic link_busy;

   ////////////////////////////////////////////////////////////////////////////
   // core domain: counter and compare

   assign wr_evt = req_sync ^ req_seen;
   assign sec_end = (sec == wutc_pkg::SEC_W'(TICK_CYCLES - 1));

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_sec = sec;
      next_irq = irq;
      if (!pin_sync) begin
         // pin low wins over a write; the new value still lands
         next_state = wutc_pkg::ST_HELD;
         next_cnt = wutc_pkg::CNT_RESET;
         next_sec = '0;
         next_irq = 1'b0;
      end else if (wr_evt) begin
         next_state = wutc_pkg::ST_COUNT;
         next_cnt = wutc_pkg::CNT_RESET;
         next_sec = '0;
         next_irq = 1'b0;
      end else begin
         case (state)
            wutc_pkg::ST_HELD: begin
               next_state = wutc_pkg::ST_COUNT;
               next_cnt = wutc_pkg::CNT_RESET;
               next_sec = '0;
               next_irq = 1'b0;
            end
            wutc_pkg::ST_COUNT: begin
               if (armed && (cnt == wake)) begin
                  next_state = wutc_pkg::ST_MATCH;
                  next_irq = 1'b1;
               end else if (cnt == wutc_pkg::CNT_MAX) begin
                  next_state = wutc_pkg::ST_SAT;
               end else if (sec_end) begin
                  next_sec = '0;
                  next_cnt = cnt + 24'h000001;
               end else begin
                  next_sec = sec + 28'h0000001;
               end
            end
            wutc_pkg::ST_MATCH: begin
               next_irq = 1'b1;
            end
            wutc_pkg::ST_SAT: begin
               next_cnt = wutc_pkg::CNT_MAX;
            end
            default: begin
               next_state = wutc_pkg::ST_HELD;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state <= wutc_pkg::ST_HELD;
         cnt <= wutc_pkg::CNT_RESET;
         sec <= '0;
         irq <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         sec <= next_sec;
         irq <= next_irq;
      end
   end

   assign int_o = irq;

   ////////////////////////////////////////////////////////////////////////////
   // core domain: stored wake value

   always_comb begin
      next_wake = wake;
      next_armed = armed;
      // wake_hold is stable while the request toggle is in flight
      // armed outlives a pin reset; only nrst_i clears it
      if (wr_evt) begin
         next_wake = wake_hold;
         next_armed = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wake <= wutc_pkg::CNT_RESET;
         armed <= 1'b0;
      end else begin
         wake <= next_wake;
         armed <= next_armed;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core domain: synchronisers and count snapshot toward the link

   always_comb begin
      next_snap_tgl = snap_tgl;
      next_snap_hold = snap_hold;
      // new snapshot only once the link has taken the previous one
      if (snap_tgl == sack_sync) begin
         next_snap_hold = cnt;
         next_snap_tgl = ~snap_tgl;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_seen <= 1'b0;
         snap_tgl <= 1'b0;
         snap_hold <= wutc_pkg::CNT_RESET;
      end else begin
         req_seen <= req_sync;
         snap_tgl <= next_snap_tgl;
         snap_hold <= next_snap_hold;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // crossings: two-stage synchronisers, only the second stage is read

   // into the core clock
   wutc_sync2 #(
      .RST_VAL(1'b0)
   ) pin_sync2_inst (
      .clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .d_i(timer_rst_n_i),
      .q_o(pin_sync)
   );

   wutc_sync2 #(
      .RST_VAL(1'b0)
   ) req_sync2_inst (
      .clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .d_i(req_tgl),
      .q_o(req_sync)
   );

   wutc_sync2 #(
      .RST_VAL(1'b0)
   ) sack_sync2_inst (
      .clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .d_i(snap_seen),
      .q_o(sack_sync)
   );

   // into the link clock
   wutc_sync2 #(
      .RST_VAL(1'b0)
   ) ack_sync2_inst (
      .clk_i(link_clk_i),
      .nrst_i(nrst_i),
      .d_i(req_seen),
      .q_o(ack_sync)
   );

   wutc_sync2 #(
      .RST_VAL(1'b0)
   ) snap_sync2_inst (
      .clk_i(link_clk_i),
      .nrst_i(nrst_i),
      .d_i(snap_tgl),
      .q_o(snap_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // link domain: wake writes

   assign link_busy = req_tgl ^ ack_sync;

   always_comb begin
      next_wake_hold = wake_hold;
      next_req_tgl = req_tgl;
      // a write during a pending one is dropped, not queued
      if (wake_wr_i && !link_busy) begin
         next_wake_hold = wake_data_i;
         next_req_tgl = ~req_tgl;
      end
      next_busy = next_req_tgl ^ ack_sync;
   end

   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wake_hold <= wutc_pkg::CNT_RESET;
         req_tgl <= 1'b0;
         busy <= 1'b0;
      end else begin
         wake_hold <= next_wake_hold;
         req_tgl <= next_req_tgl;
         busy <= next_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link domain: read-back of the live count

   always_comb begin
      next_snap_seen = snap_seen;
      next_time_rd = time_rd;
      // time_rd has no write path from the link
      // first capture after a link pause may be one snapshot old
      if (snap_sync != snap_seen) begin
         next_snap_seen = snap_sync;
         next_time_rd = snap_hold;
      end
   end

   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         snap_seen <= 1'b0;
         time_rd <= wutc_pkg::CNT_RESET;
      end else begin
         snap_seen <= next_snap_seen;
         time_rd <= next_time_rd;
      end
   end

   assign wake_busy_o = busy;
   assign wake_val_o = wake_hold;
   assign time_o = time_rd;

endmodule : wutc_core

////////////////////////////////////////////////////////////////////////////////
// two-stage synchroniser; the first stage may go metastable and is read only by the second stage

module wutc_sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic d_i,
   output logic q_o
);

   logic meta;
   logic sync;

   // reset value is 0 on every instance: idle level of the toggles, asserted level of the pin
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta <= RST_VAL;
         sync <= RST_VAL;
      end else begin
         meta <= d_i;
         sync <= meta;
      end
   end

   assign q_o = sync;

endmodule : wutc_sync2

// ---- bench/wutc_core_assertions.sv ----
// checker: port relations of the wake-up timer core
// sees only wutc_core ports; bound below, both domains cleared by nrst_i
`timescale 1ns/10ps
module wutc_chk #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic timer_rst_n_i,
   input wire logic int_o,
   input wire logic link_clk_i,
   input wire logic wake_wr_i,
   input wire logic [23:0] wake_data_i,
   input wire logic wake_busy_o,
   input wire logic [23:0] wake_val_o,
   input wire logic [23:0] time_o
);
   // set at the take edge, the earliest a compare can be armed
   logic armed;
   logic next_armed;
   always_comb next_armed = armed | (wake_wr_i & ~wake_busy_o);
   always_ff @(posedge link_clk_i or negedge nrst_i) begin
      if (!nrst_i) armed <= 1'b0;
      else armed <= next_armed;
   end
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_pin_low; !timer_rst_n_i [*3]; endsequence
   sequence s_pin_up; !timer_rst_n_i [*4] ##1 timer_rst_n_i; endsequence
   sequence s_take; wake_wr_i && !wake_busy_o; endsequence
   property p_pin_clr;
      @(posedge core_clk_i) disable iff (!nrst_i) s_pin_low |=> !int_o;
   endproperty
   a_pin_clr: assert property (p_pin_clr) else $error("int high under pin");
   property p_pin_up;
      @(posedge core_clk_i) disable iff (!nrst_i) s_pin_up |-> !int_o [*3];
   endproperty
   a_pin_up: assert property (p_pin_up) else $error("int high at pin release");
   property p_unarmed;
      @(posedge core_clk_i) disable iff (!nrst_i) !armed |-> !int_o;
   endproperty
   a_unarmed: assert property (p_unarmed) else $error("int without wake value");
   property p_pin_time;
      @(posedge link_clk_i) disable iff (!nrst_i) !timer_rst_n_i [*8] |-> time_o == 24'h000000;
   endproperty
   a_pin_time: assert property (p_pin_time) else $error("count not cleared");
   property p_take;
      @(posedge link_clk_i) disable iff (!nrst_i)
         s_take |=> wake_busy_o && wake_val_o == $past(wake_data_i);
   endproperty
   a_take: assert property (p_take) else $error("write not taken");
   property p_busy_end;
      @(posedge link_clk_i) disable iff (!nrst_i) $rose(wake_busy_o) |-> ##[1:12] !wake_busy_o;
   endproperty
   a_busy_end: assert property (p_busy_end) else $error("write never done");
   property p_val_keep;
      @(posedge link_clk_i) disable iff (!nrst_i) !wake_wr_i |=> $stable(wake_val_o);
   endproperty
   a_val_keep: assert property (p_val_keep) else $error("wake value moved");
   // snapshot lags a few cycles, so only a long match is judged
   property p_frozen;
      @(posedge link_clk_i) disable iff (!nrst_i) int_o [*8] ##1 int_o |-> $stable(time_o);
   endproperty
   a_frozen: assert property (p_frozen) else $error("count moved at match");
endmodule : wutc_chk
bind wutc_core wutc_chk #(.TICK_CYCLES(TICK_CYCLES)) wutc_chk_inst (
   .core_clk_i(core_clk_i), .nrst_i(nrst_i), .timer_rst_n_i(timer_rst_n_i), .int_o(int_o),
   .link_clk_i(link_clk_i), .wake_wr_i(wake_wr_i), .wake_data_i(wake_data_i),
   .wake_busy_o(wake_busy_o), .wake_val_o(wake_val_o), .time_o(time_o));

// ---- bench/wutc_host.sv ----
// host model: link clock, wake writes and time reads
// link clock idles high, runs only inside a transfer
`timescale 1ns/10ps
module wutc_host (
   output logic link_clk_o,
   output logic wr_o,
   output logic [23:0] data_o,
   input wire logic busy_i,
   input wire logic [23:0] time_i
);
   initial begin
      link_clk_o = 1'b1;
      wr_o = 1'b0;
      data_o = 24'h000000;
   end
   task automatic tick();
      #23 link_clk_o = 1'b0;
      #24 link_clk_o = 1'b1;
      #1;
   endtask : tick
   // whole word, next one only after busy drops
   task automatic wr(input logic [23:0] v);
      wr_o <= 1'b1;
      data_o <= v;
      tick();
      wr_o <= 1'b0;
      data_o <= ~v;
      repeat (2) tick();
      for (int n = 0; n < 20 && busy_i !== 1'b0; n++) tick();
   endtask : wr
   task automatic rd(output logic [23:0] t);
      repeat (10) tick();
      t = time_i;
   endtask : rd
endmodule : wutc_host

// ---- bench/test_wutc_core.sv ----
// testbench for the wake-up timer core, one-second tick cut to 4 cycles
// host model owns the link side; bench drives core clock and pin
`timescale 1ns/10ps
module test_wutc_core;
   logic core_clk_i = 1'b0;
   logic nrst_i = 1'b0;
   logic timer_rst_n_i = 1'b1;
   logic int_o, link_clk, wake_wr, wake_busy;
   logic [23:0] wake_data, wake_val, time_val, t1, t2;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;
   always #2 core_clk_i = ~core_clk_i;
   wutc_core #(.TICK_CYCLES(4)) wutc_core_inst (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
      .timer_rst_n_i(timer_rst_n_i), .int_o(int_o), .link_clk_i(link_clk), .wake_wr_i(wake_wr),
      .wake_data_i(wake_data), .wake_busy_o(wake_busy), .wake_val_o(wake_val), .time_o(time_val));
   wutc_host wutc_host_inst (.link_clk_o(link_clk), .wr_o(wake_wr), .data_o(wake_data),
      .busy_i(wake_busy), .time_i(time_val));
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic test_done();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : test_done
   task automatic wait_int();
      for (int n = 0; n < 400 && int_o !== 1'b1; n++) @(negedge core_clk_i);
   endtask : wait_int
   task automatic t_unarmed();
      wutc_host_inst.rd(t1);
      wutc_host_inst.rd(t2);
      check(24'(int_o), 24'h000000);
      check(24'(t2 > t1), 24'h000001);
      $display("unarmed done");
   endtask : t_unarmed
   task automatic t_match();
      wutc_host_inst.wr(24'h000005);
      check(wake_val, 24'h000005);
      wait_int();
      check(24'(int_o), 24'h000001);
      wutc_host_inst.rd(t1);
      check(t1, 24'h000005);
      wutc_host_inst.rd(t1);
      check(t1, 24'h000005);
      $display("match done");
   endtask : t_match
   task automatic t_pin();
      @(posedge core_clk_i) timer_rst_n_i <= 1'b0;
      repeat (4) @(negedge core_clk_i);
      check(24'(int_o), 24'h000000);
      wutc_host_inst.rd(t1);
      check(t1, 24'h000000);
      @(posedge core_clk_i) timer_rst_n_i <= 1'b1;
      wait_int();
      wutc_host_inst.rd(t1);
      check(t1, 24'h000005);
      $display("pin done");
   endtask : t_pin
   // value long enough that the restart is seen before the next match
   task automatic t_rewrite();
      wutc_host_inst.wr(24'h000028);
      @(negedge core_clk_i);
      check(24'(int_o), 24'h000000);
      wait_int();
      wutc_host_inst.rd(t1);
      check(t1, 24'h000028);
      $display("rewrite done");
   endtask : t_rewrite
   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end
   initial begin
      repeat (2) @(posedge core_clk_i);
      nrst_i <= 1'b1;
      t_unarmed();
      t_match();
      t_pin();
      t_rewrite();
      test_done();
   end
endmodule : test_wutc_core
